// >>> design/iscr_pkg.sv
// shared constants and types of the inductive sensor configuration registers
package iscr_pkg;
   localparam int ADDR_W = 7;
   localparam int DATA_W = 8;
   // register offsets
   localparam logic [6:0] OFS_UPPER_LIMIT = 7'h01;
   localparam logic [6:0] OFS_LOWER_LIMIT = 7'h02;
   localparam logic [6:0] OFS_WATCHDOG = 7'h03;
   localparam logic [6:0] OFS_CONFIG = 7'h04;
   localparam logic [6:0] OFS_LOCK_LAST = 7'h05;
   localparam logic [6:0] OFS_UPPER_THRESH = 7'h07;
   // reset values
   localparam logic [7:0] RST_UPPER_LIMIT = 8'h0e;
   localparam logic [7:0] RST_LOWER_LIMIT = 8'h14;
   localparam logic [7:0] RST_WATCHDOG = 8'h45;
   localparam logic [7:0] RST_CONFIG = 8'h1b;
   localparam logic [7:0] RST_UPPER_THRESH = 8'hff;
   // configuration field positions
   localparam int AMP_LSB = 3;
   localparam int RESP_LSB = 0;
   // code ranges of the resistance ladder
   localparam logic [7:0] UPPER_CODE_MAX = 8'h1f;
   localparam logic [7:0] LOWER_CODE_MIN = 8'h20;
   localparam logic [7:0] LOWER_CODE_MAX = 8'h3f;
   // response time: code 2 gives 192, each code doubles
   localparam logic [2:0] RESP_CODE_MIN = 3'h2;
   localparam logic [15:0] RESP_BASE = 16'h00c0;
   localparam logic [1:0] AMP_RESERVED = 2'h3;

   typedef enum logic [1:0] {
      AMP_1V,
      AMP_2V,
      AMP_4V,
      AMP_RSVD
   } iscr_amp_t;

   // register port request
   typedef struct packed {
      logic wr;
      logic rd;
      logic [6:0] addr;
      logic [7:0] wdata;
   } iscr_req_t;

   // decoded configuration seen by the converter
   typedef struct packed {
      logic [4:0] upper_step;
      logic [4:0] lower_step;
      logic upper_valid;
      logic lower_valid;
      logic [7:0] watchdog;
      iscr_amp_t amplitude;
      logic amp_valid;
      logic [15:0] resp_time;
      logic resp_valid;
      logic [15:0] rate_div;
      logic [7:0] thresh_high;
   } iscr_cfg_t;
endpackage

// >>> design/iscr_reg8.sv
// one 8-bit storage register with reset value and write enable
`timescale 1ns/1ps
`default_nettype none
module iscr_reg8 #(
   parameter logic [7:0] RESET_VAL = 8'h00
) (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_we,
   input wire logic [7:0] i_wdata,
   output logic [7:0] o_q
);
   logic [7:0] val_q;
   logic [7:0] val_d;

   // hold unless written; any code is kept as written
   always_comb begin
      val_d = val_q;
      if (i_we) begin
         val_d = i_wdata;
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         val_q <= RESET_VAL;
      end else begin
         val_q <= val_d;
      end
   end

   assign o_q = val_q;
endmodule
`default_nettype wire

// >>> design/iscr_top.sv
// configuration register bank of the inductive sensing converter
// Operation
// - upper impedance limit, address 0x01, read/write, resets to 0x0e.
// - upper limit codes 0x00..0x1f select descending resistance ladder steps.
// - lower impedance limit, address 0x02, read/write, resets to 0x14.
// - lower limit codes 0x20..0x3f map onto the same ladder, offset 0x20.
// - watchdog frequency setting, address 0x03, read/write, resets to 0x45.
// - converter configuration at 0x04, resets 0x1b, bits 7:5 reserved zero; here they are kept as written.
// - config bits 4:3 select amplitude 1V, 2V, 4V; code 11 reserved.
// - config bits 2:0 response time, 010 is 192, doubling to 6144.
// - upper comparator threshold, address 0x07, read/write, resets to 0xff.
// - addresses 0x01..0x05 ignore writes while active conversion is selected.
// - output rate is sensor frequency over one third of response time.
`timescale 1ns/1ps
`default_nettype none
module iscr_top (
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire iscr_pkg::iscr_req_t I_REQ,
   input wire logic I_POWER_STATE_SELECT,
   output logic [7:0] O_RDATA,
   output logic O_RVALID,
   output iscr_pkg::iscr_cfg_t O_CFG
);
   import iscr_pkg::*;

   // storage outputs of the five registers
   logic [7:0] upper_limit;
   logic [7:0] lower_limit;
   logic [7:0] watchdog;
   logic [7:0] config_r;
   logic [7:0] thresh_high;
   // write strobes, one per register
   logic we_upper;
   logic we_lower;
   logic we_wdog;
   logic we_cfg;
   logic we_thr;
   logic write_ok;
   // read path and decoded configuration registers
   logic [7:0] rdata_d;
   logic [7:0] rdata_q;
   logic rvalid_d;
   logic rvalid_q;
   iscr_cfg_t cfg_d;
   iscr_cfg_t cfg_q;

   // true for addresses frozen during active conversion
   // 0x05 sits in the range even though nothing is stored there
   function automatic logic in_lock_range(input logic [6:0] a);
      return (a >= OFS_UPPER_LIMIT) && (a <= OFS_LOCK_LAST);
   endfunction

   // one-hot select of the implemented registers, shared by write and read
   // bit 0 upper limit, 1 lower limit, 2 watchdog, 3 configuration, 4 threshold
   function automatic logic [4:0] reg_select(input logic [6:0] a);
      logic [4:0] sel;
      sel = 5'h00;
      if (a == OFS_UPPER_LIMIT) begin
         sel = 5'h01;
      end else if (a == OFS_LOWER_LIMIT) begin
         sel = 5'h02;
      end else if (a == OFS_WATCHDOG) begin
         sel = 5'h04;
      end else if (a == OFS_CONFIG) begin
         sel = 5'h08;
      end else if (a == OFS_UPPER_THRESH) begin
         sel = 5'h10;
      end
      return sel;
   endfunction

   // write lockout check
   // power state select is a level from the mode register on this clock
   assign write_ok = I_REQ.wr && !(I_POWER_STATE_SELECT && in_lock_range(I_REQ.addr));

   // write strobes per register; unmapped addresses strobe nothing
   always_comb begin
      logic [4:0] wsel;
      wsel = reg_select(I_REQ.addr);
      we_upper = 1'b0;
      we_lower = 1'b0;
      we_wdog = 1'b0;
      we_cfg = 1'b0;
      we_thr = 1'b0;
      if (write_ok && wsel[0]) begin
         we_upper = 1'b1;
      end else if (write_ok && wsel[1]) begin
         we_lower = 1'b1;
      end else if (write_ok && wsel[2]) begin
         we_wdog = 1'b1;
      end else if (write_ok && wsel[3]) begin
         we_cfg = 1'b1;
      end else if (write_ok && wsel[4]) begin
         we_thr = 1'b1;
      end
   end

   iscr_reg8 #(.RESET_VAL(RST_UPPER_LIMIT)) u_upper (
      .i_clk(I_CLOCK),
      .i_rst(I_RST),
      .i_we(we_upper),
      .i_wdata(I_REQ.wdata),
      .o_q(upper_limit)
   );

   // reset value left invalid for host
   iscr_reg8 #(.RESET_VAL(RST_LOWER_LIMIT)) u_lower (
      .i_clk(I_CLOCK),
      .i_rst(I_RST),
      .i_we(we_lower),
      .i_wdata(I_REQ.wdata),
      .o_q(lower_limit)
   );

   iscr_reg8 #(.RESET_VAL(RST_WATCHDOG)) u_wdog (
      .i_clk(I_CLOCK),
      .i_rst(I_RST),
      .i_we(we_wdog),
      .i_wdata(I_REQ.wdata),
      .o_q(watchdog)
   );

   // configuration storage
   // reserved bits kept as written so the host sees its own mistakes
   iscr_reg8 #(.RESET_VAL(RST_CONFIG)) u_cfg (
      .i_clk(I_CLOCK),
      .i_rst(I_RST),
      .i_we(we_cfg),
      .i_wdata(I_REQ.wdata),
      .o_q(config_r)
   );

   iscr_reg8 #(.RESET_VAL(RST_UPPER_THRESH)) u_thr (
      .i_clk(I_CLOCK),
      .i_rst(I_RST),
      .i_we(we_thr),
      .i_wdata(I_REQ.wdata),
      .o_q(thresh_high)
   );

   // read mux; unmapped addresses read zero
   // data holds between reads so a slow host can still take it late
   always_comb begin
      logic [4:0] rsel;
      rsel = reg_select(I_REQ.addr);
      rvalid_d = I_REQ.rd;
      rdata_d = 8'h00;
      if (!I_REQ.rd) begin
         rdata_d = rdata_q;
      end else if (rsel[0]) begin
         rdata_d = upper_limit;
      end else if (rsel[1]) begin
         rdata_d = lower_limit;
      end else if (rsel[2]) begin
         rdata_d = watchdog;
      end else if (rsel[3]) begin
         rdata_d = config_r;
      end else if (rsel[4]) begin
         rdata_d = thresh_high;
      end
   end

   // decode for the converter
   always_comb begin
      logic [2:0] resp;
      logic [7:0] lower_off;
      resp = config_r[RESP_LSB +: 3];
      lower_off = lower_limit - LOWER_CODE_MIN;
      // out-of-table lower codes wrap here; only lower_valid flags them
      cfg_d = '0;
      cfg_d.upper_step = upper_limit[4:0];
      cfg_d.upper_valid = (upper_limit <= UPPER_CODE_MAX);
      cfg_d.lower_step = lower_off[4:0];
      cfg_d.lower_valid = (lower_limit >= LOWER_CODE_MIN) && (lower_limit <= LOWER_CODE_MAX);
      cfg_d.watchdog = watchdog;
      cfg_d.amplitude = iscr_amp_t'(config_r[AMP_LSB +: 2]);
      cfg_d.amp_valid = (config_r[AMP_LSB +: 2] != AMP_RESERVED);
      // reserved time codes leave zero with the valid flag low
      // response time doubling
      cfg_d.resp_valid = (resp >= RESP_CODE_MIN);
      if (resp >= RESP_CODE_MIN) begin
         cfg_d.resp_time = RESP_BASE << (resp - RESP_CODE_MIN);
      end
      // integer division truncates; the ladder values divide exactly anyway
      // rate divider is a third of response time
      cfg_d.rate_div = cfg_d.resp_time / 16'd3;
      cfg_d.thresh_high = thresh_high;
   end

   // output registers; the registered decode costs a cycle but never glitches
   // cleared in reset, so every valid flag reads low until the first edge
   always_ff @(posedge I_CLOCK or posedge I_RST) begin
      if (I_RST) begin
         rdata_q <= 8'h00;
         rvalid_q <= 1'b0;
         cfg_q <= '0;
      end else begin
         rdata_q <= rdata_d;
         rvalid_q <= rvalid_d;
         cfg_q <= cfg_d;
      end
   end

   // ports straight from the flip-flops
   assign O_RDATA = rdata_q;
   assign O_RVALID = rvalid_q;
   assign O_CFG = cfg_q;
endmodule
`default_nettype wire

// >>> tb/iscr_assertions.sv
// assertion checker of the sensor configuration registers
`timescale 1ns/1ps
`default_nettype none
module iscr_assertions (
   input wire logic I_CLOCK,
   input wire logic I_RST,
   input wire iscr_pkg::iscr_req_t I_REQ,
   input wire logic I_POWER_STATE_SELECT,
   input wire logic [7:0] O_RDATA,
   input wire logic O_RVALID,
   input wire iscr_pkg::iscr_cfg_t O_CFG
);
   import iscr_pkg::*;
   default clocking @(posedge I_CLOCK); endclocking
   default disable iff (I_RST);
   // unlocked write of the watchdog setting, read back at once
   sequence s_wr_rd;
      I_REQ.wr && !I_POWER_STATE_SELECT && I_REQ.addr == 7'h03
      ##1 I_REQ.rd && !I_REQ.wr && I_REQ.addr == 7'h03;
   endsequence
   // the amplitude flag check skips two edges after reset; the decode still shows zero on the first
   a_read_answer: assert property (I_REQ.rd |=> O_RVALID) else $error("read late");
   a_wr_rd_back: assert property (s_wr_rd |=> O_RDATA == $past(I_REQ.wdata, 2))
      else $error("readback wrong");
   a_thresh_load: assert property (I_REQ.wr && I_REQ.addr == 7'h07
      |-> ##2 O_CFG.thresh_high == $past(I_REQ.wdata, 2)) else $error("threshold wrong");
   a_lock_hold: assert property (I_POWER_STATE_SELECT && I_REQ.wr
      && I_REQ.addr inside {[7'h01:7'h05]} |=> ##1 $stable(O_CFG)) else $error("lock open");
   a_rate_third: assert property (O_CFG.rate_div == O_CFG.resp_time / 16'd3)
      else $error("rate wrong");
   a_resp_steps: assert property (O_CFG.resp_valid |-> O_CFG.resp_time inside
      {16'd192, 16'd384, 16'd768, 16'd1536, 16'd3072, 16'd6144}) else $error("time wrong");
   a_amp_flag: assert property (!$past(I_RST, 2)
      |-> O_CFG.amp_valid == (O_CFG.amplitude != AMP_RSVD)) else $error("amp flag wrong");
   a_reset_vals: assert property ($past(I_RST, 2) && !$past(I_RST)
      |-> O_CFG.watchdog == 8'h45 && O_CFG.thresh_high == 8'hff && !O_CFG.lower_valid
      && O_CFG.upper_step == 5'h0e && O_CFG.resp_time == 16'd384) else $error("reset wrong");
endmodule
bind iscr_top iscr_assertions iscr_assertions_inst (.I_CLOCK, .I_RST, .I_REQ,
   .I_POWER_STATE_SELECT, .O_RDATA, .O_RVALID, .O_CFG);
`default_nettype wire

// >>> tb/iscr_host.sv
// host model issuing one-cycle register requests
`timescale 1ns/1ps
`default_nettype none
module iscr_host (
   input wire logic i_clk,
   output var iscr_pkg::iscr_req_t o_req
);
   import iscr_pkg::*;
   initial o_req = '0;
   // request held until the edge that takes it; caller starts on an edge
   task automatic put(input logic w, input logic [6:0] a, input logic [7:0] d);
      o_req <= '{w, !w, a, d};
      @(posedge i_clk);
   endtask
   // released fields flip so stale values never look valid
   task automatic idle();
      o_req <= '{1'b0, 1'b0, ~o_req.addr, ~o_req.wdata};
   endtask
   // start-up writes, then a back-to-back readback
   task automatic boot();
      @(posedge i_clk);
      put(1'b1, 7'h02, 8'h20);
      put(1'b1, 7'h03, 8'hb3);
      put(1'b0, 7'h03, 8'h00);
      idle();
   endtask
endmodule
`default_nettype wire

// >>> tb/iscr_top_tb.sv
// self-checking bench of the sensor configuration registers
`timescale 1ns/1ps
`default_nettype none
module iscr_top_tb;
   import iscr_pkg::*;
   logic clk = 1'b0;
   logic rst = 1'b1;
   logic psel = 1'b0;
   iscr_req_t req;
   logic [7:0] rdata;
   logic rvalid;
   iscr_cfg_t cfg;
   int failures = 0;
   int compares = 0;
   iscr_top iscr_top_inst (.I_CLOCK(clk), .I_RST(rst), .I_REQ(req),
      .I_POWER_STATE_SELECT(psel), .O_RDATA(rdata), .O_RVALID(rvalid), .O_CFG(cfg));
   iscr_host iscr_host_inst (.i_clk(clk), .o_req(req));
   // 10 MHz clock
   initial forever #50 clk = ~clk;
   task automatic check(input logic [15:0] got, input logic [15:0] exp);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   // decode lags the write by one edge, so wait it out
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge clk);
      iscr_host_inst.put(1'b1, a, d);
      iscr_host_inst.idle();
      @(posedge clk);
      @(negedge clk);
   endtask
   task automatic rd(input logic [6:0] a, input logic [7:0] e);
      @(posedge clk);
      iscr_host_inst.put(1'b0, a, 8'h00);
      iscr_host_inst.idle();
      @(negedge clk);
      check(rvalid, 1'b1);
      check(rdata, e);
   endtask
   // ladder ends and the first codes above them, stored as written
   task automatic t_ladder();
      logic [7:0] c [3] = '{8'h00, 8'h1f, 8'h20};
      foreach (c[i]) begin
         wr(7'h01, c[i]);
         wr(7'h02, c[i] + 8'h20);
         check(cfg.upper_step, c[i][4:0]);
         check(cfg.upper_valid, c[i] < 8'h20);
         check(cfg.lower_valid, c[i] < 8'h20);
         check(cfg.lower_step, c[i][4:0]);
         rd(7'h01, c[i]);
         rd(7'h02, c[i] + 8'h20);
      end
   endtask
   // every amplitude and response code, reserved top bits written as 101
   task automatic t_config();
      logic [7:0] v;
      logic [15:0] e;
      for (int c = 0; c < 8; c++) begin
         v = {3'b101, c[1:0], c[2:0]};
         e = c < 2 ? 16'h0000 : 16'h00c0 << (c - 2);
         wr(7'h04, v);
         check(cfg.amplitude, v[4:3]);
         check(cfg.amp_valid, v[4:3] != 2'h3);
         check(cfg.resp_time, e);
         check(cfg.resp_valid, c >= 2);
         check(cfg.rate_div, e / 16'd3);
         rd(7'h04, v);
      end
   endtask
   // converting: upper limit and config locked, threshold still open
   task automatic t_lock();
      @(posedge clk);
      psel <= 1'b1;
      wr(7'h01, 8'h05);
      wr(7'h04, 8'h0a);
      wr(7'h07, 8'h5a);
      rd(7'h01, 8'h20);
      rd(7'h04, 8'hbf);
      rd(7'h07, 8'h5a);
      check(cfg.thresh_high, 8'h5a);
      @(posedge clk);
      psel <= 1'b0;
      wr(7'h01, 8'h05);
      rd(7'h01, 8'h05);
   endtask
   task automatic print_verdict();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      rst <= 1'b0;
      rd(7'h01, 8'h0e);
      rd(7'h02, 8'h14);
      rd(7'h03, 8'h45);
      rd(7'h04, 8'h1b);
      rd(7'h07, 8'hff);
      iscr_host_inst.boot();
      rd(7'h03, 8'hb3);
      check(cfg.watchdog, 8'hb3);
      t_ladder();
      t_config();
      t_lock();
      print_verdict();
   end
endmodule
`default_nettype wire
